// [ftl_regs.vh]
// Register offsets, field positions, reset values and thresholds for the FIFO status, test and length register block
`ifndef FTL_REGS_VH
`define FTL_REGS_VH
`define FTL_ADDR_TEST_CONTROL_TWO 5'h1b
`define FTL_ADDR_FIFO_FILL_STATUS 5'h1c
`define FTL_ADDR_TX_LENGTH_UPPER 5'h1d
`define FTL_ADDR_TX_LENGTH_LOWER 5'h1e
`define FTL_RESET_TEST 8'h00
`define FTL_RESET_TXLEN 8'h00
`define FTL_TEST_RF_AMPLITUDE_CHECK 7
`define FTL_TEST_IO_CHECK_SEL_HI 3
`define FTL_TEST_IO_CHECK_SEL_LO 2
`define FTL_TEST_DEC 1
`define FTL_TEST_CODER_FAST_CLOCK 0
`define FTL_STAT_HIGH 6
`define FTL_STAT_LOW 5
`define FTL_STAT_OVERFLOW 4
`define FTL_LOWER_PARTIAL_FLAG 0
`define FTL_FIFO_DEPTH 32
`define FTL_FIFO_AW 5
`define FTL_FIFO_CW 6
`define FTL_HIGH_LEVEL 6'h09
`define FTL_LOW_LEVEL 6'h03
`endif

// [ftl_fifo.v]
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ftl_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk_i,
   input wire reset_i,
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [AW:0] count_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   assign in_ready_o = (count_reg != DEPTH[AW:0]);
   assign out_valid_o = (count_reg != {(AW+1){1'b0}});
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr_reg];
   assign count_o = count_reg;
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end
   always @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // ftl_fifo
`default_nettype wire

// [ftl_top.v]
// FIFO status, second test register and transmit-length registers
//
// Operation
// R01: Setting decoder test or I/O test bits enters test mode.
// R02: Test mode holds until host stop; stop clears decoder and I/O test bits.
// R03: Second test register resets to zero on power-on or chip enable low.
// R04: Test bit B0 runs coders directly at the fast clock.
// R05: Status B6 asserts in receive once nine bytes are held.
// R06: Status B5 asserts in transmit when only three bytes remain.
// R07: Status B4 flags overflow when host writes into a full FIFO.
// R08: Status B3..B0 report unread bytes minus one.
// R09: Status B7 always reads zero.
// R10: Upper length register holds count bits 11 to 4.
// R11: Lower length bits B7..B4 hold count bits 3 to 0.
// R12: Both length registers reset to zero and clear at transmit end-of-frame.
// R13: Lower length B3..B1 give bits of the final partial byte.
// R14: Partial bit count is used only when the partial flag is set.
// R15: Lower length B0 set means last byte is sent as partial.
// R16: Host programs length before loading data and starting transmission.
`timescale 1ns/1ps
`default_nettype none
`include "ftl_regs.vh"
module ftl_top (
   input wire clk_i,
   input wire reset_i,
   input wire chip_enable_i,
   input wire [4:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   input wire host_stop_i,
   input wire rx_active_i,
   input wire tx_active_i,
   input wire tx_eof_i,
   input wire fifo_wr_i,
   input wire [7:0] fifo_wdata_i,
   input wire fifo_rd_i,
   output reg [7:0] fifo_rdata_o,
   output reg fifo_rdata_valid_o,
   output reg fifo_wr_ready_o,
   output reg test_mode_o,
   output reg coder_fast_clock_o,
   output reg io_check_sel_hi_o,
   output reg io_check_sel_lo_o,
   output reg rf_amplitude_check_o,
   output reg decoder_test_o,
   output reg [11:0] tx_byte_count_o,
   output reg [2:0] tx_partial_bits_o,
   output reg tx_partial_o
);
   reg ce_meta_reg;
   reg ce_sync_reg;
   reg stop_meta_reg;
   reg stop_sync_reg;
   reg stop_prev_reg;
   reg [7:0] test_control_two_reg;
   reg [7:0] tx_length_upper_reg;
   reg [7:0] tx_length_lower_reg;
   reg overflow_reg;
   reg [7:0] rdata_next;
   wire clear_all;
   wire stop_edge;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire [`FTL_FIFO_CW-1:0] fifo_count;
   wire [7:0] status_value;
   wire [3:0] unread_nibble;
   wire fill_high;
   wire fill_low;
   wire wr_hit_test;
   wire wr_hit_upper;
   wire wr_hit_lower;

   function match;
      input [4:0] addr;
      input [4:0] target;
      begin
         match = (addr == target);
      end
   endfunction

   // Chip enable and host stop arrive from pins
   always @(posedge clk_i) begin
      if (reset_i) begin
         ce_meta_reg <= 1'b0;
         ce_sync_reg <= 1'b0;
         stop_meta_reg <= 1'b0;
         stop_sync_reg <= 1'b0;
         stop_prev_reg <= 1'b0;
      end else begin
         ce_meta_reg <= chip_enable_i;
         ce_sync_reg <= ce_meta_reg;
         stop_meta_reg <= host_stop_i;
         stop_sync_reg <= stop_meta_reg;
         stop_prev_reg <= stop_sync_reg;
      end
   end

   assign stop_edge = stop_sync_reg && !stop_prev_reg;
   assign clear_all = reset_i || !ce_sync_reg;
   assign wr_hit_test = reg_wr_i && match(reg_addr_i, `FTL_ADDR_TEST_CONTROL_TWO);
   assign wr_hit_upper = reg_wr_i && match(reg_addr_i, `FTL_ADDR_TX_LENGTH_UPPER);
   assign wr_hit_lower = reg_wr_i && match(reg_addr_i, `FTL_ADDR_TX_LENGTH_LOWER);

   ftl_fifo #(
      .WIDTH(8),
      .DEPTH(`FTL_FIFO_DEPTH),
      .AW(`FTL_FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(clear_all),
      .in_data_i(fifo_wdata_i),
      .in_valid_i(fifo_wr_i),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_rd_i),
      .count_o(fifo_count)
   );

   // R03 cleared at power-on or chip enable low
   always @(posedge clk_i) begin
      if (clear_all) begin
         test_control_two_reg <= `FTL_RESET_TEST;
      end else if (wr_hit_test) begin
         // R01 writing test bits enters test mode
         test_control_two_reg <= reg_wdata_i;
      end else if (stop_edge) begin
         // R02 stop clears decoder and I/O tests
         test_control_two_reg[`FTL_TEST_DEC] <= 1'b0;
         test_control_two_reg[`FTL_TEST_IO_CHECK_SEL_HI] <= 1'b0;
         test_control_two_reg[`FTL_TEST_IO_CHECK_SEL_LO] <= 1'b0;
      end
   end

   // R12 reset and end-of-frame clear
   always @(posedge clk_i) begin
      if (clear_all) begin
         tx_length_upper_reg <= `FTL_RESET_TXLEN;
         tx_length_lower_reg <= `FTL_RESET_TXLEN;
      end else if (tx_eof_i) begin
         tx_length_upper_reg <= `FTL_RESET_TXLEN;
         tx_length_lower_reg <= `FTL_RESET_TXLEN;
      end else begin
         // R10 upper count bits
         if (wr_hit_upper) begin
            tx_length_upper_reg <= reg_wdata_i;
         end
         // R11 lower count and partial info
         if (wr_hit_lower) begin
            tx_length_lower_reg <= reg_wdata_i;
         end
      end
   end

   // R07 overflow sticky; set wins over read clear
   always @(posedge clk_i) begin
      if (clear_all) begin
         overflow_reg <= 1'b0;
      end else if (fifo_wr_i && !fifo_in_ready) begin
         overflow_reg <= 1'b1;
      end else if (reg_rd_i && match(reg_addr_i, `FTL_ADDR_FIFO_FILL_STATUS)) begin
         overflow_reg <= 1'b0;
      end
   end

   // R05 high level while receiving
   assign fill_high = rx_active_i && (fifo_count >= `FTL_HIGH_LEVEL);
   // R06 low level while transmitting
   assign fill_low = tx_active_i && (fifo_count <= `FTL_LOW_LEVEL);
   // R08 count minus one; empty shows zero
   assign unread_nibble = (fifo_count == 6'h00) ? 4'h0 : fifo_count[3:0] - 4'h1;
   // R09 reserved bit zero
   assign status_value = {1'b0, fill_high, fill_low, overflow_reg, unread_nibble};

   always @* begin
      rdata_next = 8'h00;
      case (reg_addr_i)
         `FTL_ADDR_TEST_CONTROL_TWO: begin
            rdata_next = test_control_two_reg;
         end
         `FTL_ADDR_FIFO_FILL_STATUS: begin
            rdata_next = status_value;
         end
         `FTL_ADDR_TX_LENGTH_UPPER: begin
            rdata_next = tx_length_upper_reg;
         end
         `FTL_ADDR_TX_LENGTH_LOWER: begin
            rdata_next = tx_length_lower_reg;
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
         fifo_rdata_o <= 8'h00;
         fifo_rdata_valid_o <= 1'b0;
         fifo_wr_ready_o <= 1'b0;
         test_mode_o <= 1'b0;
         coder_fast_clock_o <= 1'b0;
         io_check_sel_hi_o <= 1'b0;
         io_check_sel_lo_o <= 1'b0;
         rf_amplitude_check_o <= 1'b0;
         decoder_test_o <= 1'b0;
         tx_byte_count_o <= 12'h000;
         tx_partial_bits_o <= 3'h0;
         tx_partial_o <= 1'b0;
      end else begin
         reg_rdata_o <= rdata_next;
         fifo_rdata_o <= fifo_out_data;
         fifo_rdata_valid_o <= fifo_out_valid && fifo_rd_i;
         fifo_wr_ready_o <= fifo_in_ready;
         // R01 test mode from decoder or I/O test bits
         test_mode_o <= test_control_two_reg[`FTL_TEST_DEC] ||
            test_control_two_reg[`FTL_TEST_IO_CHECK_SEL_HI] ||
            test_control_two_reg[`FTL_TEST_IO_CHECK_SEL_LO];
         // R04 coder fast clock select
         coder_fast_clock_o <= test_control_two_reg[`FTL_TEST_CODER_FAST_CLOCK];
         io_check_sel_hi_o <= test_control_two_reg[`FTL_TEST_IO_CHECK_SEL_HI];
         io_check_sel_lo_o <= test_control_two_reg[`FTL_TEST_IO_CHECK_SEL_LO];
         rf_amplitude_check_o <= test_control_two_reg[`FTL_TEST_RF_AMPLITUDE_CHECK];
         decoder_test_o <= test_control_two_reg[`FTL_TEST_DEC];
         // R10 R11 complete-byte count
         tx_byte_count_o <= {tx_length_upper_reg, tx_length_lower_reg[7:4]};
         // R15 partial flag
         tx_partial_o <= tx_length_lower_reg[`FTL_LOWER_PARTIAL_FLAG];
         // R13 R14 partial bits only with flag
         tx_partial_bits_o <= tx_length_lower_reg[`FTL_LOWER_PARTIAL_FLAG] ?
            tx_length_lower_reg[3:1] : 3'h0;
      end
   end
endmodule // ftl_top
`default_nettype wire

// [ftl_host_model.sv]
// Host controller model driving the register port and stop pin
`timescale 1ns/1ps
`default_nettype none
module ftl_host_model (
   input wire logic clk_i,
   input wire logic [7:0] reg_rdata_i,
   output logic [4:0] reg_addr_o = 5'h00,
   output logic reg_wr_o = 1'b0,
   output logic reg_rd_o = 1'b0,
   output logic [7:0] reg_wdata_o = 8'h00,
   output logic host_stop_o = 1'b0
);
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      // Scrambled so a stale value cannot pass
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
   endtask
   task automatic stop;
      @(negedge clk_i);
      host_stop_o = 1'b1;
      repeat (6) @(negedge clk_i);
      host_stop_o = 1'b0;
   endtask
endmodule // ftl_host_model
`default_nettype wire

// [ftl_top_assertions.sv]
// Assertions on the status, test and length register block
`timescale 1ns/1ps
`default_nettype none
module ftl_top_assertions (
   input wire clk_i,
   input wire reset_i,
   input wire [4:0] reg_addr_i,
   input wire reg_wr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire host_stop_i,
   input wire tx_eof_i,
   input wire fifo_rd_i,
   input wire fifo_rdata_valid_o,
   input wire test_mode_o,
   input wire coder_fast_clock_o,
   input wire io_check_sel_hi_o,
   input wire io_check_sel_lo_o,
   input wire decoder_test_o,
   input wire [11:0] tx_byte_count_o,
   input wire [2:0] tx_partial_bits_o,
   input wire tx_partial_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_upper_wr;
      reg_wr_i && reg_addr_i == 5'h1d && !tx_eof_i;
   endsequence
   sequence s_stop_edge;
      !host_stop_i ##1 host_stop_i;
   endsequence
   AST_STAT_B7: assert property (reg_addr_i == 5'h1c |=> !reg_rdata_o[7])
      else $error("status bit 7 set");
   AST_TEST_MODE: assert property ((decoder_test_o || io_check_sel_hi_o || io_check_sel_lo_o)
      |-> ##[0:1] test_mode_o)
      else $error("test mode missing");
   AST_STOP_CLEAR: assert property (s_stop_edge |-> ##[1:4]
      !(decoder_test_o || io_check_sel_hi_o || io_check_sel_lo_o))
      else $error("stop left test bits");
   AST_EOF_CLEAR: assert property (tx_eof_i |-> ##[1:2]
      (tx_byte_count_o == 12'h000 && !tx_partial_o))
      else $error("length kept after eof");
   AST_UPPER_MAP: assert property (s_upper_wr |-> ##2
      tx_byte_count_o[11:4] == $past(reg_wdata_i, 2))
      else $error("upper count wrong");
   AST_FAST_CLOCK: assert property (reg_wr_i && reg_addr_i == 5'h1b |-> ##2
      coder_fast_clock_o == $past(reg_wdata_i[0], 2))
      else $error("fast clock bit wrong");
   AST_PARTIAL_GATE: assert property (!tx_partial_o |-> tx_partial_bits_o == 3'h0)
      else $error("partial bits without flag");
   AST_POP_VALID: assert property (fifo_rdata_valid_o |-> $past(fifo_rd_i))
      else $error("valid without pop");
endmodule // ftl_top_assertions
bind ftl_top ftl_top_assertions u_chk (.clk_i(clk_i), .reset_i(reset_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .host_stop_i(host_stop_i), .tx_eof_i(tx_eof_i),
   .fifo_rd_i(fifo_rd_i), .fifo_rdata_valid_o(fifo_rdata_valid_o),
   .test_mode_o(test_mode_o), .coder_fast_clock_o(coder_fast_clock_o),
   .io_check_sel_hi_o(io_check_sel_hi_o), .io_check_sel_lo_o(io_check_sel_lo_o),
   .decoder_test_o(decoder_test_o), .tx_byte_count_o(tx_byte_count_o),
   .tx_partial_bits_o(tx_partial_bits_o), .tx_partial_o(tx_partial_o));
`default_nettype wire

// [ftl_top_bench.sv]
// Self-checking bench for the status, test and length register block
`timescale 1ns/1ps
`default_nettype none
module ftl_top_bench;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ce = 1'b1;
   logic rx_on = 1'b0;
   logic tx_on = 1'b0;
   logic eof = 1'b0;
   logic f_wr = 1'b0;
   logic f_rd = 1'b0;
   logic [7:0] f_wd = 8'h00;
   logic [7:0] rv;
   wire [4:0] r_a;
   wire r_wr, r_rd, stp, f_v, t_md, fclk, tx_pf;
   wire io_hi, io_lo, rf_chk, dec_t, wr_rdy;
   wire [7:0] r_wd, r_q, f_q;
   wire [11:0] tx_cnt;
   wire [2:0] tx_bb;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   always #10 clk_i = ~clk_i;
   ftl_host_model host (.clk_i(clk_i), .reg_rdata_i(r_q), .reg_addr_o(r_a), .reg_wr_o(r_wr),
      .reg_rd_o(r_rd), .reg_wdata_o(r_wd), .host_stop_o(stp));
   ftl_top DUT (.clk_i(clk_i), .reset_i(reset_i), .chip_enable_i(ce), .reg_addr_i(r_a),
      .reg_wr_i(r_wr), .reg_rd_i(r_rd), .reg_wdata_i(r_wd), .reg_rdata_o(r_q),
      .host_stop_i(stp), .rx_active_i(rx_on), .tx_active_i(tx_on), .tx_eof_i(eof),
      .fifo_wr_i(f_wr), .fifo_wdata_i(f_wd), .fifo_rd_i(f_rd), .fifo_rdata_o(f_q),
      .fifo_rdata_valid_o(f_v), .fifo_wr_ready_o(wr_rdy), .test_mode_o(t_md),
      .coder_fast_clock_o(fclk), .io_check_sel_hi_o(io_hi), .io_check_sel_lo_o(io_lo),
      .rf_amplitude_check_o(rf_chk), .decoder_test_o(dec_t), .tx_byte_count_o(tx_cnt),
      .tx_partial_bits_o(tx_bb), .tx_partial_o(tx_pf));
   task automatic chk(input string n, input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic push(input logic [7:0] d);
      @(negedge clk_i);
      f_wr = 1'b1;
      f_wd = d;
      @(negedge clk_i);
      f_wr = 1'b0;
      f_wd = ~d;
   endtask
   task automatic pop(input logic [7:0] exp);
      int n;
      @(negedge clk_i);
      f_rd = 1'b1;
      @(negedge clk_i);
      f_rd = 1'b0;
      for (n = 0; n < 3 && f_v !== 1'b1; n++) @(negedge clk_i);
      chk("pop data", f_q, exp);
   endtask
   task automatic t_reset;
      host.rd(5'h1b, rv); chk("test reg", rv, 8'h00);
      host.rd(5'h1c, rv); chk("status", rv, 8'h00);
      host.rd(5'h1d, rv); chk("len upper", rv, 8'h00);
      host.rd(5'h1f, rv); chk("unmapped", rv, 8'h00);
   endtask
   task automatic t_test;
      host.wr(5'h1b, 8'h8f);
      host.rd(5'h1b, rv); chk("test reg", rv, 8'h8f);
      chk("test mode", t_md, 1'b1);
      chk("fast clock", fclk, 1'b1);
      chk("io hi pin", io_hi, 1'b1);
      chk("io lo pin", io_lo, 1'b1);
      chk("decoder pin", dec_t, 1'b1);
      chk("rf check pin", rf_chk, 1'b1);
      host.stop();
      host.rd(5'h1b, rv); chk("after stop", rv, 8'h81);
      chk("mode after stop", t_md, 1'b0);
      chk("io hi cleared", io_hi, 1'b0);
      chk("io lo cleared", io_lo, 1'b0);
      chk("decoder cleared", dec_t, 1'b0);
      chk("rf check kept", rf_chk, 1'b1);
      chk("fast clock kept", fclk, 1'b1);
   endtask
   task automatic t_ce;
      host.wr(5'h1b, 8'h02);
      host.wr(5'h1d, 8'h55);
      @(negedge clk_i) ce = 1'b0;
      repeat (4) @(negedge clk_i);
      ce = 1'b1;
      repeat (4) @(negedge clk_i);
      host.rd(5'h1b, rv); chk("test reg ce", rv, 8'h00);
      host.rd(5'h1d, rv); chk("upper ce", rv, 8'h00);
      chk("mode ce", t_md, 1'b0);
      chk("count ce", tx_cnt, 12'h000);
   endtask
   task automatic t_len;
      host.wr(5'h1d, 8'hab);
      host.wr(5'h1e, 8'hcb);
      host.rd(5'h1e, rv); chk("len lower", rv, 8'hcb);
      chk("byte count", tx_cnt, 12'habc);
      chk("partial bits", tx_bb, 3'h5);
      chk("partial flag", tx_pf, 1'b1);
      host.wr(5'h1e, 8'hca);
      host.rd(5'h1e, rv);
      chk("bits no flag", tx_bb, 3'h0);
      @(negedge clk_i) eof = 1'b1;
      @(negedge clk_i) eof = 1'b0;
      host.rd(5'h1d, rv); chk("upper eof", rv, 8'h00);
      host.rd(5'h1e, rv); chk("lower eof", rv, 8'h00);
   endtask
   task automatic t_fifo;
      int i;
      host.wr(5'h1d, 8'h02);
      rx_on = 1'b1;
      for (i = 0; i < 9; i++) push(i[7:0]);
      host.rd(5'h1c, rv); chk("high level", rv, 8'h48);
      rx_on = 1'b0;
      tx_on = 1'b1;
      for (i = 0; i < 6; i++) pop(i[7:0]);
      host.rd(5'h1c, rv); chk("low level", rv, 8'h22);
      tx_on = 1'b0;
      // Fill to 32, then one more
      for (i = 9; i < 39; i++) push(i[7:0]);
      host.rd(5'h1c, rv); chk("overflow", rv, 8'h1f);
      host.rd(5'h1c, rv); chk("ovf cleared", rv, 8'h0f);
      chk("ready when full", wr_rdy, 1'b0);
      for (i = 6; i < 38; i++) pop(i[7:0]);
      host.rd(5'h1c, rv); chk("drained", rv, 8'h00);
      chk("ready when empty", wr_rdy, 1'b1);
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) reset_i = 1'b0;
      repeat (3) @(negedge clk_i);
      t_reset();
      t_test();
      t_len();
      t_fifo();
      t_ce();
      report_and_stop();
   end
endmodule // ftl_top_bench
`default_nettype wire
